// ### rtl/dod_pkg.sv
/*
  Package of the opcode decoder and sequencer: field positions, opcode
  patterns, vector layout and the enumerated types of the block.
  Assumes 24-bit instruction words and a 14-bit program address space.
*/
package dod_pkg;
  // ==========================================================================
  // Word and address widths.
  // ==========================================================================
  localparam int WORD_W = 24;                   // Instruction word width.
  localparam int ADDR_W = 14;                   // Program and data address width.

  // ==========================================================================
  // Sequencing constants.
  // ==========================================================================
  localparam logic [13:0] RESTART_ADDR = 14'h0000; // First fetch after reset.
  localparam int          VEC_SHIFT    = 2;        // Four words per vector.

  // ==========================================================================
  // Opcode patterns, compared against the top bits of the word.
  // ==========================================================================
  localparam logic [1:0] PAT_ALU_DUAL    = 2'h3;  // Bits 23..22.
  localparam logic [2:0] PAT_IMM_DATA_WR  = 3'h5; // Bits 23..21.
  localparam logic [2:0] PAT_IMM_ADDR_XFR = 3'h4; // Bits 23..21.
  localparam logic [2:0] PAT_ALU_DATA_MEM = 3'h3; // Bits 23..21.
  localparam logic [3:0] PAT_ALU_PROG_MEM = 4'h5; // Bits 23..20.

  // ==========================================================================
  // Field positions (least significant bit of each field).
  // ==========================================================================
  localparam int F_PROG_DST_LSB = 20;           // Program fetch destination.
  localparam int F_DATA_DST_LSB = 18;           // Data fetch destination.
  localparam int F_FUNC_LSB = 13;               // Function code, 5 bits.
  localparam int F_Y_LSB    = 11;               // Y operand, 2 bits.
  localparam int F_X_LSB    = 8;                // X operand, 3 bits.
  localparam int F_PMI_LSB  = 6;                // Program memory index select.
  localparam int F_PMM_LSB  = 4;                // Program memory modify select.
  localparam int F_IDX_LSB  = 2;                // Data memory index select.
  localparam int F_MOD_LSB  = 0;                // Data memory modify select.
  localparam int F_UNIT_BIT = 20;               // Address generator unit select.
  localparam int F_DIR3_BIT = 20;               // Direction in immediate address form.
  localparam int F_DIR_BIT  = 19;               // Direction in ALU forms.
  localparam int F_Z_BIT    = 18;               // Y operand zero flag.
  localparam int F_DATA_LSB = 4;                // Immediate data, 16 bits.
  localparam int F_ADDR_LSB = 4;                // Immediate address, 14 bits.
  localparam int F_GROUP_LSB = 18;              // Register group, 2 bits.
  localparam int F_DPREG_LSB = 4;               // Datapath register, 4 bits.

  // ==========================================================================
  // Types.
  // ==========================================================================
  // Decoded opcode type; everything else is reserved here.
  typedef enum logic [2:0] {
    OP_RSV          = 3'h0,
    OP_ALU_DUAL     = 3'h1,
    OP_IMM_DATA_WR  = 3'h2,
    OP_IMM_ADDR_XFR = 3'h3,
    OP_ALU_DATA_MEM = 3'h4,
    OP_ALU_PROG_MEM = 3'h5
  } dod_op_type;

  // Sequencer state, Gray coded.
  typedef enum logic [0:0] {
    SEQ_RUN  = 1'h0,
    SEQ_IDLE = 1'h1
  } dod_seq_type;
endpackage : dod_pkg

// ### rtl/dod_decoder.sv
/*
  Instruction decoder for opcode types one to five, with program sequencing
  (restart, vectors, idle) and the circular address step.
  Assumes program memory returns the word for prog_addr in the same cycle,
  and that the execution stage reports idle and interrupt return as pulses.
*/
`timescale 1ns/1ps
// Contract
// - Bits 23,22 set: dual-fetch ALU/MAC type
// - Pattern 101: data write of immediate
// - Pattern 100: data access, immediate address
// - Pattern 011: ALU/MAC with data transfer
// - Pattern 0101: ALU/MAC with program transfer
// - Other encodings decode as reserved
// - Dual memory fetch takes one cycle
// - Compute on old operands while fetching
// - Fetch starts at address 0000 after reset
// - Vectors four words, enter first word
// - Idle waits for interrupt, resume after
// - Nonzero length gives modulo wraparound
module dod_decoder
#(
  parameter int NIRQ = 6                                // Number of interrupt lines.
)
(
  input  wire logic                       mclk,         // Core clock.
  input  wire logic                       reset_n,      // Asynchronous reset.
  input  wire logic [dod_pkg::WORD_W-1:0] prog_word,    // Word at prog_addr.
  input  wire logic [NIRQ-1:0]            irq_req,      // Enabled pending interrupts.
  input  wire logic                       idle_cmd,     // Idle instruction executed.
  input  wire logic                       irq_return,   // Return from interrupt executed.
  input  wire logic [dod_pkg::ADDR_W-1:0] ag_index,     // Index register value.
  input  wire logic [dod_pkg::ADDR_W-1:0] ag_modify,    // Modify value, signed.
  input  wire logic [dod_pkg::ADDR_W-1:0] ag_length,    // Buffer length.
  input  wire logic [dod_pkg::ADDR_W-1:0] ag_base,      // Buffer start address.
  output dod_pkg::dod_op_type             op_type,      // Decoded type.
  output logic                            op_valid,     // Decoded fields are live.
  output logic [1:0]                      prog_fetch_reg, // Program fetch target.
  output logic [1:0]                      data_fetch_reg, // Data fetch target.
  output logic [4:0]                      func_code,    // ALU/MAC function.
  output logic [1:0]                      y_operand,    // Y operand select.
  output logic [2:0]                      x_operand,    // X operand select.
  output logic [1:0]                      prog_mem_index,  // Program index select.
  output logic [1:0]                      prog_mem_modify, // Program modify select.
  output logic [1:0]                      data_mem_index,  // Data index select.
  output logic [1:0]                      data_mem_modify, // Data modify select.
  output logic                            unit_sel,     // Address generator unit.
  output logic                            dir_write,    // Transfer is a write.
  output logic                            y_zero,       // Y operand forced to zero.
  output logic [3:0]                      datapath_register, // Register select.
  output logic [1:0]                      reg_group,    // Register group.
  output logic [15:0]                     imm_data,     // Immediate data.
  output logic [dod_pkg::ADDR_W-1:0]      imm_addr,     // Immediate address.
  output logic                            data_mem_en,  // Data memory access.
  output logic                            prog_mem_en,  // Program memory access.
  output logic                            mac_compute,  // Compute on held operands.
  output logic [dod_pkg::ADDR_W-1:0]      prog_addr,    // Fetch address.
  output logic                            halted,       // Idle wait in progress.
  output logic [NIRQ-1:0]                 irq_ack,      // Interrupt taken pulse.
  output logic [dod_pkg::ADDR_W-1:0]      ag_next       // Post-modified address.
);
  import dod_pkg::*;

  // ==========================================================================
  // Combinational decode of the fetched word.
  // ==========================================================================
  wire logic       hit_dual = (prog_word[23:22] == PAT_ALU_DUAL);
  wire logic       hit_imd  = (prog_word[23:21] == PAT_IMM_DATA_WR);
  wire logic       hit_ima  = (prog_word[23:21] == PAT_IMM_ADDR_XFR);
  wire logic       hit_adm  = (prog_word[23:21] == PAT_ALU_DATA_MEM);
  wire logic       hit_apm  = (prog_word[23:20] == PAT_ALU_PROG_MEM);
  wire dod_op_type dec_type = hit_dual ? OP_ALU_DUAL :
                              hit_imd  ? OP_IMM_DATA_WR :
                              hit_ima  ? OP_IMM_ADDR_XFR :
                              hit_adm  ? OP_ALU_DATA_MEM :
                              hit_apm  ? OP_ALU_PROG_MEM : OP_RSV;
  // Direction sits at bit 20 in the immediate address form only.
  wire logic       dec_dir  = hit_ima ? prog_word[F_DIR3_BIT] : prog_word[F_DIR_BIT];
  // Memory enables; the dual form drives both in the same cycle.
  wire logic       dec_dmem = hit_dual | hit_imd | hit_ima | hit_adm;
  wire logic       dec_pmem = hit_dual | hit_apm;
  wire logic       dec_mac  = hit_dual | hit_adm | hit_apm;

  // ==========================================================================
  // Sequencer decisions.
  // ==========================================================================
  dod_seq_type           state;        // Run or idle wait.
  dod_seq_type           next_state;   // Next sequencer state.
  logic                  in_service;   // An interrupt routine is active.
  logic [ADDR_W-1:0]     ret_addr;     // Address to resume at on return.
  logic [$clog2(NIRQ)-1:0] irq_sel;    // Highest priority pending line.

  // Lowest numbered pending line wins.
  always_comb
  begin
    irq_sel = '0;
    for (int k = NIRQ - 1; k >= 0; k--)
    begin
      if (irq_req[k])
      begin
        irq_sel = k[$clog2(NIRQ)-1:0];
      end
    end
  end

  wire logic              irq_any  = |irq_req;
  wire logic              take_irq = irq_any & ~in_service & ~irq_return;
  // Vector n sits at four times n plus four, behind the restart slot.
  wire logic [ADDR_W-1:0] vec_addr = ADDR_W'((32'(irq_sel) + 32'd1) << VEC_SHIFT);
  wire logic              go_idle  = (state == SEQ_RUN) & idle_cmd & ~take_irq;
  wire logic              run_on   = (state == SEQ_RUN) & ~idle_cmd;

  // Next state: idle is left only by a taken interrupt.
  always_comb
  begin
    case (state)
      SEQ_RUN:  next_state = go_idle ? SEQ_IDLE : SEQ_RUN;
      SEQ_IDLE: next_state = take_irq ? SEQ_RUN : SEQ_IDLE;
      default:  next_state = SEQ_RUN;
    endcase
  end

  // Next fetch address; return outranks entry, entry outranks idle.
  wire logic [ADDR_W-1:0] next_pc = irq_return ? ret_addr :
                                    take_irq   ? vec_addr :
                                    run_on     ? prog_addr + 14'h0001 :
                                    prog_addr;

  // ==========================================================================
  // Circular address step.
  // ==========================================================================
  wire logic [ADDR_W-1:0]   lin_sum = ag_index + ag_modify;              // Linear step.
  wire logic signed [15:0]  ofs     = 16'({2'h0, ag_index}) - 16'({2'h0, ag_base})
                                      + 16'({{2{ag_modify[ADDR_W-1]}}, ag_modify});
  wire logic signed [15:0]  len_s   = 16'({2'h0, ag_length});
  wire logic signed [15:0]  wrapped = (ofs >= len_s) ? ofs - len_s :
                                      (ofs < 16'sh0000) ? ofs + len_s : ofs;
  // Zero length keeps plain linear addressing.
  wire logic [ADDR_W-1:0]   next_ag = (ag_length == 14'h0000) ? lin_sum :
                                      ag_base + wrapped[ADDR_W-1:0];

  // ==========================================================================
  // Sequencer registers.
  // ==========================================================================
  // Program counter, state and return address.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_addr  <= RESTART_ADDR;
      state      <= SEQ_RUN;
      in_service <= 1'b0;
      ret_addr   <= RESTART_ADDR;
      halted     <= 1'b0;
      irq_ack    <= '0;
    end
    else
    begin
      prog_addr  <= next_pc;
      state      <= next_state;
      halted     <= (next_state == SEQ_IDLE);
      irq_ack    <= take_irq ? NIRQ'(1) << irq_sel : '0;
      // Entry saves the next unfetched address, so return resumes after idle.
      if (take_irq)
      begin
        in_service <= 1'b1;
        ret_addr   <= (state == SEQ_RUN && !idle_cmd) ? prog_addr + 14'h0001 : prog_addr;
      end
      else if (irq_return)
      begin
        in_service <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Decoded field registers.
  // ==========================================================================
  // The word present is decoded only while the sequencer runs without an idle command; dir_write latches every cycle.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_type     <= OP_RSV;
      op_valid    <= 1'b0;
      data_mem_en <= 1'b0;
      prog_mem_en <= 1'b0;
      mac_compute <= 1'b0;
      dir_write   <= 1'b0;
    end
    else
    begin
      op_valid    <= run_on;
      op_type     <= run_on ? dec_type : OP_RSV;
      data_mem_en <= run_on & dec_dmem;
      prog_mem_en <= run_on & dec_pmem;
      mac_compute <= run_on & dec_mac;
      dir_write   <= dec_dir;
    end
  end

  // Raw field slices; their meaning follows op_type.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_fetch_reg    <= '0;
      data_fetch_reg    <= '0;
      func_code         <= '0;
      y_operand         <= '0;
      x_operand         <= '0;
      prog_mem_index    <= '0;
      prog_mem_modify   <= '0;
      data_mem_index    <= '0;
      data_mem_modify   <= '0;
      unit_sel          <= 1'b0;
      y_zero            <= 1'b0;
      datapath_register <= '0;
      reg_group         <= '0;
      imm_data          <= '0;
      imm_addr          <= '0;
      ag_next           <= '0;
    end
    else
    begin
      prog_fetch_reg    <= prog_word[F_PROG_DST_LSB +: 2];
      data_fetch_reg    <= prog_word[F_DATA_DST_LSB +: 2];
      func_code         <= prog_word[F_FUNC_LSB +: 5];
      y_operand         <= prog_word[F_Y_LSB +: 2];
      x_operand         <= prog_word[F_X_LSB +: 3];
      prog_mem_index    <= prog_word[F_PMI_LSB +: 2];
      prog_mem_modify   <= prog_word[F_PMM_LSB +: 2];
      data_mem_index    <= prog_word[F_IDX_LSB +: 2];
      data_mem_modify   <= prog_word[F_MOD_LSB +: 2];
      unit_sel          <= prog_word[F_UNIT_BIT];
      y_zero            <= prog_word[F_Z_BIT];
      // Low four bits name the register in the immediate address form.
      datapath_register <= hit_ima ? prog_word[3:0] : prog_word[F_DPREG_LSB +: 4];
      reg_group         <= prog_word[F_GROUP_LSB +: 2];
      imm_data          <= prog_word[F_DATA_LSB +: 16];
      imm_addr          <= prog_word[F_ADDR_LSB +: ADDR_W];
      ag_next           <= next_ag;
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  // A word of the given form is taken while the sequencer runs.
  sequence s_run_word(logic hit);
    run_on && hit;
  endsequence

  AST_RESTART: assert property (@(posedge mclk) $rose(reset_n) |-> prog_addr == 14'h0000)
    else $error("Fetch did not start at the restart address.");
  AST_DUAL: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_dual) |=> op_type == OP_ALU_DUAL && data_mem_en && prog_mem_en)
    else $error("Dual fetch form not decoded.");
  AST_IMM_DATA: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_imd) |=> op_type == OP_IMM_DATA_WR && imm_data == $past(prog_word[19:4]))
    else $error("Immediate data write not decoded.");
  AST_IMM_ADDR: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_ima) |=> op_type == OP_IMM_ADDR_XFR && dir_write == $past(prog_word[20]))
    else $error("Immediate address access not decoded.");
  AST_ALU_DATA_MEM: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_adm) |=> op_type == OP_ALU_DATA_MEM && data_mem_en && !prog_mem_en)
    else $error("ALU with data transfer not decoded.");
  AST_ALU_PROG_MEM: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_apm) |=> op_type == OP_ALU_PROG_MEM && prog_mem_en && !data_mem_en)
    else $error("ALU with program transfer not decoded.");
  AST_RESERVED: assert property (@(posedge mclk) disable iff (!reset_n)
    (prog_word[23:20] < 4'h5) |=> op_type == OP_RSV && !data_mem_en && !mac_compute)
    else $error("Reserved encoding given a function.");
  AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!reset_n)
    s_run_word(hit_dual && !take_irq && !irq_return) |=> prog_addr == $past(prog_addr) + 14'h0001)
    else $error("Dual fetch added a cycle.");
  AST_OVERLAP: assert property (@(posedge mclk) disable iff (!reset_n)
    op_type == OP_ALU_DUAL |-> mac_compute && data_mem_en && prog_mem_en)
    else $error("Compute and fetch did not overlap.");
  AST_VECTOR: assert property (@(posedge mclk) disable iff (!reset_n)
    take_irq && !irq_return |=> prog_addr[1:0] == 2'h0 && prog_addr != 14'h0000 && irq_ack != '0)
    else $error("Interrupt did not enter a vector's first word.");
  AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    halted && !irq_any && !irq_return |=> $stable(prog_addr) && halted)
    else $error("Idle did not hold execution.");
  AST_RETURN: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_return |=> prog_addr == $past(ret_addr))
    else $error("Return did not resume at the saved address.");
  AST_LINEAR: assert property (@(posedge mclk) disable iff (!reset_n)
    ag_length == 14'h0000 |=> ag_next == $past(lin_sum))
    else $error("Zero length did not give linear addressing.");
  AST_MODULO: assert property (@(posedge mclk) disable iff (!reset_n)
    ag_length != 14'h0000 && ofs >= 16'sh0000 && ofs < len_s + len_s
    |=> ag_next - $past(ag_base) < $past(ag_length))
    else $error("Circular address left the buffer.");
  // While the sequencer waits in idle no word is decoded.
  AST_IDLE_REFUSE: assert property (@(posedge mclk) disable iff (!reset_n)
    halted |-> !op_valid && op_type == OP_RSV && !data_mem_en && !prog_mem_en)
    else $error("A word was decoded during idle.");
endmodule : dod_decoder

// ### tb/dod_prog_mem.sv
/*
  Program memory model that feeds instruction words to the decoder.
  Assumes the decoder expects the word for prog_addr within the same cycle.
*/
`timescale 1ns/1ps
module dod_prog_mem
(
  input  wire logic [dod_pkg::ADDR_W-1:0] prog_addr,  // Fetch address from the sequencer.
  output logic      [dod_pkg::WORD_W-1:0] prog_word   // Word stored at that address.
);
  import dod_pkg::*;
  // ==========================================================================
  // Storage and read path.
  // ==========================================================================
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];  // Word store, loaded by the bench.

  // Unused words read as zero, which decodes as a reserved encoding.
  initial
  begin
    for (int a = 0; a < (1 << ADDR_W); a++)
    begin
      mem[a] = 24'h000000;
    end
  end

  // The read is combinational, so a fetch completes in the cycle it is issued.
  assign prog_word = mem[prog_addr];
endmodule : dod_prog_mem

// ### tb/dod_decoder_tb.sv
/*
  Self-checking bench of the opcode decoder and sequencer.
  Assumes the program memory model answers in the same cycle.
*/
`timescale 1ns/1ps
module dod_decoder_tb;
  import dod_pkg::*;
  // ==========================================================================
  // Signals.
  // ==========================================================================
  logic mclk, reset_n, idle_cmd, irq_return, op_valid, unit_sel, dir_write, y_zero;
  logic data_mem_en, prog_mem_en, mac_compute, halted;
  logic [WORD_W-1:0] prog_word;
  logic [5:0] irq_req, irq_ack;
  logic [ADDR_W-1:0] ag_index, ag_modify, ag_length, ag_base, imm_addr, prog_addr, ag_next;
  dod_op_type op_type;
  logic [1:0] prog_fetch_reg, data_fetch_reg, y_operand, prog_mem_index, prog_mem_modify;
  logic [1:0] data_mem_index, data_mem_modify, reg_group;
  logic [4:0] func_code;
  logic [2:0] x_operand;
  logic [3:0] datapath_register;
  logic [15:0] imm_data;
  int miscompares = 0;                        // Mismatches seen.
  int tests_run   = 0;                        // Comparisons made.
  int cycles      = 0;                        // Clock cycles since start.

  dod_decoder #(.NIRQ(6)) i_dod_decoder
  (
    .mclk, .reset_n, .prog_word, .irq_req, .idle_cmd, .irq_return, .ag_index, .ag_modify,
    .ag_length, .ag_base, .op_type, .op_valid, .prog_fetch_reg, .data_fetch_reg,
    .func_code, .y_operand, .x_operand, .prog_mem_index, .prog_mem_modify, .data_mem_index,
    .data_mem_modify, .unit_sel, .dir_write, .y_zero, .datapath_register, .reg_group, .imm_data,
    .imm_addr, .data_mem_en, .prog_mem_en, .mac_compute, .prog_addr, .halted, .irq_ack, .ag_next
  );
  dod_prog_mem i_dod_prog_mem (.prog_addr, .prog_word);

  // ==========================================================================
  // Clock, timeout and shared tasks.
  // ==========================================================================
  always #4 mclk = ~mclk;

  // A hang is cut short well past the 36 or so cycles the run needs.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // Waits for an edge and lets its updates land before driving or sampling.
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  // Loads one word of each type, holds reset, then checks the first fetch.
  task automatic test_reset();
    i_dod_prog_mem.mem[0] = 24'hE7F5DB;
    i_dod_prog_mem.mem[1] = 24'hBABCD6;
    i_dod_prog_mem.mem[2] = 24'h9C0127;
    i_dod_prog_mem.mem[3] = 24'h7600F0;
    i_dod_prog_mem.mem[4] = 24'h580000;
    repeat (19) tick();
    check(prog_addr, 14'h0000);
    reset_n = 1'b1;
  endtask : test_reset

  // Decodes the five types and a reserved word back to back, one per cycle.
  task automatic test_decode();
    tick();
    check({op_type, func_code}, {OP_ALU_DUAL, 5'h1F});
    check({prog_fetch_reg, data_fetch_reg, y_operand, x_operand}, 9'h135);
    check({prog_mem_index, prog_mem_modify, data_mem_index, data_mem_modify}, 8'hDB);
    check({data_mem_en, prog_mem_en, mac_compute, op_valid}, 4'hF);
    check(prog_addr, 14'h0001);
    tick();
    check(op_type, OP_IMM_DATA_WR);
    check({unit_sel, imm_data, data_mem_index, data_mem_modify}, 21'h1ABCD6);
    tick();
    check(op_type, OP_IMM_ADDR_XFR);
    check({dir_write, reg_group, imm_addr, datapath_register}, {3'h7, 14'h0012, 4'h7});
    tick();
    check({op_type, unit_sel, dir_write, y_zero}, {OP_ALU_DATA_MEM, 3'b101});
    check({datapath_register, data_mem_en, prog_mem_en, mac_compute}, {4'hF, 3'b101});
    tick();
    check({op_type, dir_write, prog_mem_en, data_mem_en}, {OP_ALU_PROG_MEM, 3'b110});
    check(mac_compute, 1'b1);
    tick();
    check({op_type, data_mem_en, prog_mem_en, mac_compute}, {OP_RSV, 3'b000});
  endtask : test_decode

  // Idles at address 6, takes line 2 over line 3, returns after the idle.
  task automatic test_idle_irq();
    idle_cmd = 1'b1;
    tick();
    idle_cmd = 1'b0;
    repeat (3) tick();
    check({halted, op_valid, prog_addr}, {2'b10, 14'h0006});
    irq_req = 6'h0C;
    tick();
    irq_req = 6'h00;
    check({halted, irq_ack, prog_addr}, {1'b0, 6'h04, 14'h000C});
    tick();
    check({irq_ack, prog_addr}, {6'h00, 14'h000D});
    irq_return = 1'b1;
    tick();
    irq_return = 1'b0;
    check(prog_addr, 14'h0006);
  endtask : test_idle_irq

  // Applies one address step and checks the post-modified result.
  task automatic step(input logic [13:0] idx, input logic [13:0] mdf,
                      input logic [13:0] len, input logic [13:0] exp);
    ag_index  = idx;
    ag_modify = mdf;
    ag_length = len;
    tick();
    check(ag_next, exp);
  endtask : step

  // Linear step, wrap past the top and wrap below the base of an 8-word buffer.
  task automatic test_addr_step();
    ag_base = 14'h0100;
    step(14'h0107, 14'h0001, 14'h0000, 14'h0108);
    step(14'h0107, 14'h0001, 14'h0008, 14'h0100);
    step(14'h0100, 14'h3FFE, 14'h0008, 14'h0106);
  endtask : test_addr_step

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial
  begin
    {mclk, reset_n, idle_cmd, irq_return, irq_req} = '0;
    {ag_index, ag_modify, ag_length, ag_base} = '0;
    tick();
    test_reset();
    test_decode();
    test_idle_irq();
    test_addr_step();
    stop_test();
  end
endmodule : dod_decoder_tb
